// >>> pfm_assertions.sv
// concurrent checks on the pin function multiplexer ports
`timescale 1ns/1ns
`default_nettype none
module pfm_assertions
  import pfm_pkg::*;
(
  // clock, reset, enable
  input wire logic               sys_clk_i,
  input wire logic               rst_n_i,
  input wire logic               ce_i,
  // watched ports
  input wire logic [NPIN-1:0]    pad_out_o,
  input wire logic [NPIN-1:0]    pad_oe_o,
  input wire logic [NPIN-1:0]    pad_pu_o,
  input wire logic [7:0]         ana_en_o,
  input wire logic [11:0]        sel_pa_i,
  input wire logic [15:0]        sel_pb_i,
  input wire logic [7:0]         pc_gpio_sel_i,
  input wire logic [3:0]         pd_gpio_sel_i,
  input wire pfm_pkg::pfm_cko_t  clock_out_source_select_i,
  input wire logic [NPIN-1:0]    gpio_dir_i,
  input wire logic [NPIN-1:0]    gpio_dout_i,
  input wire logic               cko_mstr_i,
  input wire logic               sw_rst_i,
  input wire logic               chip_rst_n_o,
  input wire logic               spi_master_i,
  input wire logic [5:0]         modulator_out_i,
  input wire logic [5:0]         fault_mask_i,
  input wire logic               tck_rise_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_gpio_drive: assert property (ce_i && sel_pa_i[1:0] == FN_GPIO |=>
    pad_oe_o[0] == $past(gpio_dir_i[0]) && pad_out_o[0] == $past(gpio_dout_i[0]))
    else $error("port A0 drive not from port registers");
  a_mod_drive: assert property (ce_i && sel_pa_i[1:0] == FN_ALT1 && !fault_mask_i[0] |=>
    pad_oe_o[0] && pad_out_o[0] == $past(modulator_out_i[0]))
    else $error("modulator output missing on A0");
  a_cko_master: assert property (ce_i && sel_pb_i[9:8] == FN_ALT2 &&
    clock_out_source_select_i == CKO_MSTR |=> pad_oe_o[12] && pad_out_o[12] == $past(cko_mstr_i))
    else $error("clock out not following system clock");
  a_cko_off: assert property (ce_i && sel_pb_i[9:8] == FN_ALT2 &&
    clock_out_source_select_i == CKO_OFF |=> pad_oe_o[12] && !pad_out_o[12])
    else $error("disabled clock out not low");
  a_sclk_dir: assert property (ce_i && sel_pb_i[1:0] == FN_ALT1 |=>
    pad_oe_o[8] == $past(spi_master_i))
    else $error("SPI clock pin direction wrong");
  a_miso_master: assert property (ce_i && sel_pb_i[5:4] == FN_ALT1 && spi_master_i |=>
    !pad_oe_o[10])
    else $error("master drives its data input pin");
  a_analog_sel: assert property (ce_i |=> ana_en_o == ~$past(pc_gpio_sel_i))
    else $error("converter connection wrong");
  a_test_pullup: assert property (ce_i && !pd_gpio_sel_i[2] |=> pad_pu_o[PIN_TCK])
    else $error("test clock pull-up missing");
  a_soft_reset: assert property (ce_i && sw_rst_i |=> !chip_rst_n_o)
    else $error("software reset not seen");
  a_rise_pulse: assert property (ce_i && tck_rise_o |=> !tck_rise_o)
    else $error("test clock rise pulse too long");
endmodule

bind pfm_top pfm_assertions u_chk (.*);
`default_nettype wire

// >>> pfm_board.sv
// board model: pad level resolution and a test port tester
`timescale 1ns/1ns
`default_nettype none
module pfm_board
  import pfm_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic [NPIN-1:0] pad_out_i,
  input  wire logic [NPIN-1:0] pad_oe_i,
  input  wire logic [NPIN-1:0] pad_pu_i,
  input  wire logic [NPIN-1:0] ext_en_i,
  input  wire logic [NPIN-1:0] ext_val_i,
  output logic      [NPIN-1:0] pad_in_o
);
  logic tck;
  logic tms;
  logic tdi;
  // test clock stands high between bits, as its pull-up would hold it
  initial begin
    tck = 1'h1;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // a floating pad without pull-up shows the inverse of its last drive
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pad_in_o[i] = ext_en_i[i] ? ext_val_i[i] :
                    pad_oe_i[i] ? pad_out_i[i] : (pad_pu_i[i] | ~pad_out_i[i]);
    end
    pad_in_o[PIN_TCK] = tck;
    pad_in_o[PIN_TMS] = tms;
    pad_in_o[PIN_TDI] = tdi;
  end
  // mode and data set while clock low
  task automatic tap_bit(input logic m, input logic d);
    @(negedge sys_clk_i);
    tck = 1'h0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge sys_clk_i);
    tck = 1'h1;
    repeat (4) @(negedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// >>> pfm_jtag_if.sv
// synchronised test pins and test data output between mux and test pin logic
`timescale 1ns/1ns
`default_nettype none
interface pfm_jtag_if;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tdo_val;
  logic tdo_en;
  modport mux (output tck_s, output tms_s, output tdi_s, input tdo_val, input tdo_en);
  modport tap (input tck_s, input tms_s, input tdi_s, output tdo_val, output tdo_en);
endinterface
`default_nettype wire

// >>> pfm_jtag_pins.sv
// test clock edge detection, mode/data sampling and test data output timing
`timescale 1ns/1ns
`default_nettype none
module pfm_jtag_pins (
  // clock, reset, enable
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // pins side
  pfm_jtag_if.tap   jt,
  // test controller side
  input  wire logic tap_shift_i,
  input  wire logic tdo_data_i,
  output logic      tck_rise_o,
  output logic      tms_o,
  output logic      tdi_o
);
  logic tck_d_r;
  logic tdo_val_r;
  logic tdo_en_r;

  wire tck_rise = jt.tck_s & ~tck_d_r;
  wire tck_fall = ~jt.tck_s & tck_d_r;

  assign jt.tdo_val = tdo_val_r;
  assign jt.tdo_en  = tdo_en_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tck_d_r    <= 1'b1;
      tck_rise_o <= 1'b0;
      tms_o      <= 1'b1;
      tdi_o      <= 1'b1;
      tdo_val_r  <= 1'b0;
      tdo_en_r   <= 1'b0;
    end else if (ce_i) begin
      tck_d_r    <= jt.tck_s;
      tck_rise_o <= tck_rise;
      // mode select taken on test clock rise
      if (tck_rise) tms_o <= jt.tms_s;
      // data input taken on test clock rise
      if (tck_rise) tdi_o <= jt.tdi_s;
      // output and its enable move on test clock fall; enable high in shift states only
      if (tck_fall) begin
        tdo_val_r <= tdo_data_i;
        tdo_en_r  <= tap_shift_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> pfm_pkg.sv
// constants and types shared by the pin function multiplexer
package pfm_pkg;
  // pin index map: port A 0..7, port B 8..15, port C 16..23, port D 24..27
  localparam int unsigned NPIN     = 28;
  localparam int unsigned PA_BASE  = 0;
  localparam int unsigned PB_BASE  = 8;
  localparam int unsigned PC_BASE  = 16;
  localparam int unsigned PD_BASE  = 24;
  localparam int unsigned PIN_RST  = PA_BASE + 7;
  localparam int unsigned PIN_TDI  = PD_BASE + 0;
  localparam int unsigned PIN_TCK  = PD_BASE + 2;
  localparam int unsigned PIN_TMS  = PD_BASE + 3;

  // function select codes, one 2-bit field per port B pin and per port A pin 0..5
  localparam logic [1:0] FN_GPIO  = 2'h0;
  localparam logic [1:0] FN_ALT1  = 2'h1;
  localparam logic [1:0] FN_ALT2  = 2'h2;
  localparam logic [1:0] FN_ALT3  = 2'h3;
  typedef logic [1:0] pfm_fn_t;

  // clock_out_source_select codes
  localparam logic [1:0] CKO_OFF  = 2'h0;
  localparam logic [1:0] CKO_MSTR = 2'h1;
  localparam logic [1:0] CKO_BUS  = 2'h2;
  localparam logic [1:0] CKO_OSC  = 2'h3;
  typedef logic [1:0] pfm_cko_t;

  // which alternates each port exists for
  localparam logic [7:0] PA_ALT1_MASK = 8'h37;
  localparam logic [7:0] PA_ALT23_MASK = 8'h30;
  localparam logic [7:0] PB_ALT3_MASK = 8'h40;
  // pads without a pull-up: absent A3/A6
  localparam logic [7:0] PA_ABSENT    = 8'h48;

  // reset values
  localparam logic [NPIN-1:0] PAD_PU_RST = 28'hF00FFB7;
  localparam logic [NPIN-1:0] PAD_OE_RST = 28'h0000000;
  localparam logic [NPIN-1:0] SYNC_RST   = 28'hFFFFFFF;
  localparam logic [7:0]      ANA_EN_RST = 8'hFF;

  // internal reset release after the last reset source goes away
  localparam int unsigned RST_RELEASE_CYC = 32;

  typedef enum logic [2:0] {
    RS_HOLD  = 3'b001,
    RS_COUNT = 3'b010,
    RS_RUN   = 3'b100
  } pfm_rst_state_e;
endpackage

// >>> pfm_rst_ctl.sv
// internal reset sequencer: pin, watchdog and software reset sources
`timescale 1ns/1ns
`default_nettype none
module pfm_rst_ctl #(
  parameter int unsigned REL_CYC = pfm_pkg::RST_RELEASE_CYC
) (
  // clock, reset, enable
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // sources
  input  wire logic pin_is_gpio_i,
  input  wire logic rst_pin_lvl_i,
  input  wire logic wdog_rst_i,
  input  wire logic sw_rst_i,
  // result
  output logic      chip_rst_n_o
);
  import pfm_pkg::*;

  localparam int unsigned CW = $clog2(REL_CYC + 1);

  if (REL_CYC < 1 || REL_CYC > 65536) begin : g_chk
    $error("pfm_rst_ctl: REL_CYC out of range");
  end

  pfm_rst_state_e st_r, st_nxt;
  logic [CW-1:0]  cnt_r, cnt_nxt;

  // pin reset only while the pin keeps its reset function
  wire pin_req  = ~pin_is_gpio_i & ~rst_pin_lvl_i;
  wire any_req  = pin_req | wdog_rst_i | sw_rst_i;
  wire cnt_done = (cnt_r == CW'(REL_CYC - 1));

  // hold while asserted, release a fixed count later
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      RS_HOLD: begin
        cnt_nxt = '0;
        if (!any_req) st_nxt = RS_COUNT;
      end
      RS_COUNT: begin
        cnt_nxt = cnt_r + CW'(1);
        if (any_req) begin
          st_nxt = RS_HOLD;
        end else if (cnt_done) begin
          st_nxt = RS_RUN;
        end
      end
      RS_RUN: begin
        if (any_req) st_nxt = RS_HOLD;
      end
      default: st_nxt = RS_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r         <= RS_HOLD;
      cnt_r        <= '0;
      chip_rst_n_o <= 1'b0;
    end else if (ce_i) begin
      st_r         <= st_nxt;
      cnt_r        <= cnt_nxt;
      chip_rst_n_o <= (st_nxt == RS_RUN);
    end
  end
endmodule
`default_nettype wire

// >>> pfm_top.sv
// pin function multiplexer: pad drive, pull-ups and peripheral input routing
`timescale 1ns/1ns
`default_nettype none
module pfm_top #(
  parameter int unsigned REL_CYC   = pfm_pkg::RST_RELEASE_CYC,
  parameter logic        FAULT_ACT = 1'b1
) (
  // clock, reset, enable
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  // pads (A 0..7, B 8..15, C 16..23, D 24..27)
  input  wire logic [pfm_pkg::NPIN-1:0]  pad_in_i,
  output logic      [pfm_pkg::NPIN-1:0]  pad_out_o,
  output logic      [pfm_pkg::NPIN-1:0]  pad_oe_o,
  output logic      [pfm_pkg::NPIN-1:0]  pad_pu_o,
  output logic      [7:0]                ana_en_o,
  // function selects from system_integration_module
  input  wire logic [11:0]               sel_pa_i,
  input  wire logic                      rst_pin_gpio_i,
  input  wire logic [15:0]               sel_pb_i,
  input  wire logic [7:0]                pc_gpio_sel_i,
  input  wire logic [3:0]                pd_gpio_sel_i,
  input  wire pfm_pkg::pfm_cko_t         clock_out_source_select_i,
  input  wire logic                      oscillator_source_bit_i,
  // general-purpose port registers
  input  wire logic [pfm_pkg::NPIN-1:0]  gpio_dir_i,
  input  wire logic [pfm_pkg::NPIN-1:0]  gpio_dout_i,
  output logic      [pfm_pkg::NPIN-1:0]  gpio_in_o,
  // clock-out sources, as levels
  input  wire logic                      cko_mstr_i,
  input  wire logic                      cko_bus_i,
  input  wire logic                      cko_osc_i,
  output logic                           ext_clk_in_o,
  // reset sources and result
  input  wire logic                      wdog_rst_i,
  input  wire logic                      sw_rst_i,
  output logic                           chip_rst_n_o,
  // SPI
  input  wire logic                      spi_master_i,
  input  wire logic                      spi_sclk_drv_i,
  input  wire logic                      spi_miso_drv_i,
  input  wire logic                      spi_mosi_drv_i,
  output logic                           spi_sclk_rcv_o,
  output logic                           spi_ss_n_o,
  output logic                           spi_miso_rcv_o,
  output logic                           spi_mosi_rcv_o,
  // I2C, open drain: *_low_i pulls the line low
  input  wire logic                      i2c_scl_low_i,
  input  wire logic                      i2c_sda_low_i,
  output logic                           i2c_scl_rcv_o,
  output logic                           i2c_sda_rcv_o,
  // serial communications
  input  wire logic                      sci_txd_i,
  input  wire logic                      sci_single_wire_i,
  input  wire logic                      sci_txd_oe_i,
  output logic                           sci_rxd_o,
  // timers
  input  wire logic [3:0]                tmr_drv_i,
  input  wire logic [3:0]                tmr_oe_i,
  output logic      [3:0]                tmr_rcv_o,
  // modulator and faults
  input  wire logic [5:0]                modulator_out_i,
  input  wire logic [5:0]                fault_mask_i,
  output logic      [2:0]                fault_o,
  // test controller
  input  wire logic                      tap_shift_i,
  input  wire logic                      tdo_data_i,
  output logic                           tck_rise_o,
  output logic                           tms_o,
  output logic                           tdi_o
);
  import pfm_pkg::*;

  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [7:0]      a_alt1, a_alt2, a_alt3;
  logic [7:0]      b_alt1, b_alt2, b_alt3;

  for (genvar i = 0; i < 8; i++) begin : g_fn
    if (i < 6) begin : g_a
      assign a_alt1[i] = PA_ALT1_MASK[i] && (sel_pa_i[2*i+:2] == FN_ALT1);
      assign a_alt2[i] = PA_ALT23_MASK[i] && (sel_pa_i[2*i+:2] == FN_ALT2);
      assign a_alt3[i] = PA_ALT23_MASK[i] && (sel_pa_i[2*i+:2] == FN_ALT3);
    end else begin : g_a_none
      assign a_alt1[i] = 1'b0;
      assign a_alt2[i] = 1'b0;
      assign a_alt3[i] = 1'b0;
    end
    assign b_alt1[i] = (sel_pb_i[2*i+:2] == FN_ALT1);
    assign b_alt2[i] = (sel_pb_i[2*i+:2] == FN_ALT2);
    assign b_alt3[i] = PB_ALT3_MASK[i] && (sel_pb_i[2*i+:2] == FN_ALT3);
  end

  wire [7:0] s_a = sync2_r[PA_BASE+:8];
  wire [7:0] s_b = sync2_r[PB_BASE+:8];

  // fault pins are inputs; any active one blocks the masked channels
  wire [2:0] fault_sel = {b_alt2[5], a_alt2[5], a_alt2[4]};
  wire [2:0] fault_lvl = {s_b[5], s_a[5], s_a[4]};
  wire [2:0] fault_nxt = fault_sel & ~(fault_lvl ^ {3{FAULT_ACT}});
  wire [5:0] mod_ok    = modulator_out_i & ~(fault_mask_i & {6{|fault_nxt}});

  // buffered_clock_out source; off reads as constant zero
  wire cko_lvl = (clock_out_source_select_i == CKO_MSTR) ? cko_mstr_i :
                 (clock_out_source_select_i == CKO_BUS)  ? cko_bus_i  :
                 (clock_out_source_select_i == CKO_OSC)  ? cko_osc_i  : 1'b0;

  // slave select from the external master, low means addressed
  wire ss_n_nxt = b_alt1[1] ? s_b[1] : 1'b1;

  pfm_jtag_if jt ();

  // port A: modulator, fault and timer alternates; bit 7 is the reset pin
  // reset function unless reprogrammed as port_a_bit7
  wire [7:0] a_peri = {~rst_pin_gpio_i, 1'b1, a_alt1[5:4] | a_alt2[5:4] | a_alt3[5:4],
                       1'b1, a_alt1[2:0]};
  // modulator channels 0,1,2,4,5; timer 2 on A4, timer 3 on A5
  wire a4_out = a_alt1[4] ? mod_ok[4] : tmr_drv_i[2];
  wire a5_out = a_alt1[5] ? mod_ok[5] : tmr_drv_i[3];
  wire a4_oe  = a_alt1[4] | (a_alt3[4] & tmr_oe_i[2]);
  wire a5_oe  = a_alt1[5] | (a_alt3[5] & tmr_oe_i[3]);
  wire [7:0] a_pout = {2'b00, a5_out, a4_out, 1'b0, mod_ok[2:0]};
  wire [7:0] a_poe  = {2'b00, a5_oe, a4_oe, 1'b0, 3'b111};

  // port B
  // bit 6 has a third alternate, the external clock input
  wire [7:0] b_peri = b_alt1 | b_alt2 | b_alt3;
  // clock drives only as master; I2C pins pull low only
  wire b0_oe = b_alt1[0] ? spi_master_i : i2c_scl_low_i;
  wire b1_oe = b_alt2[1] & i2c_sda_low_i;
  // slave drives MISO only while addressed, master listens
  wire b2_oe = b_alt1[2] ? (~spi_master_i & ~ss_n_nxt) : tmr_oe_i[2];
  wire b3_oe = b_alt1[3] ? spi_master_i : tmr_oe_i[3];
  wire b4_oe = b_alt1[4] ? tmr_oe_i[0] : 1'b1;
  wire b5_oe = b_alt1[5] & tmr_oe_i[1];
  wire b6_oe = b_alt2[6] & i2c_sda_low_i;
  // single-wire lets the serial block turn the transmit pin around
  wire b7_oe = b_alt1[7] ? (sci_single_wire_i ? sci_txd_oe_i : 1'b1) : i2c_scl_low_i;
  // data and clock share one pipeline, so the half-cycle lead survives
  wire [7:0] b_pout = {b_alt1[7] & sci_txd_i,
                       1'b0,
                       tmr_drv_i[1],
                       b_alt1[4] ? tmr_drv_i[0] : cko_lvl,
                       b_alt1[3] ? spi_mosi_drv_i : tmr_drv_i[3],
                       b_alt1[2] ? spi_miso_drv_i : tmr_drv_i[2],
                       1'b0,
                       b_alt1[0] & spi_sclk_drv_i};
  wire [7:0] b_poe  = {b7_oe, b6_oe, b5_oe, b4_oe, b3_oe, b2_oe, b1_oe, b0_oe};

  // analog is the primary use of port C, no digital drive
  wire [7:0] c_peri = ~pc_gpio_sel_i;
  // test pins; only the data output ever drives
  wire [3:0] d_peri = ~pd_gpio_sel_i;
  wire [3:0] d_pout = {2'b00, jt.tdo_val, 1'b0};
  wire [3:0] d_poe  = {2'b00, jt.tdo_en, 1'b0};

  wire [NPIN-1:0] peri  = {d_peri, c_peri, b_peri, a_peri};
  wire [NPIN-1:0] pout  = {d_pout, 8'h00, b_pout, a_pout};
  wire [NPIN-1:0] poe   = {d_poe, 8'h00, b_poe, a_poe};
  wire [NPIN-1:0] no_pu = {4'h0, c_peri, 8'h00, PA_ABSENT};

  // port_a_bit7 is open drain, drives only a low
  wire [NPIN-1:0] g_out = {gpio_dout_i[NPIN-1:8], 1'b0, gpio_dout_i[6:0]};
  wire [NPIN-1:0] g_oe  = {gpio_dir_i[NPIN-1:8], gpio_dir_i[7] & ~gpio_dout_i[7],
                           gpio_dir_i[6:0]};

  // peripheral owns drive while selected, port registers otherwise
  wire [NPIN-1:0] out_nxt = (peri & pout) | (~peri & g_out);
  wire [NPIN-1:0] oe_nxt  = (peri & poe) | (~peri & g_oe);
  // undriven pins keep a pull-up; analog and absent pads none
  wire [NPIN-1:0] pu_nxt  = ~oe_nxt & ~no_pu;

  // primary pins B0, B1, B2, B3 win over the second copy
  wire scl_nxt  = b_alt2[0] ? s_b[0] : (b_alt2[7] ? s_b[7] : 1'b1);
  wire sda_nxt  = b_alt2[1] ? s_b[1] : (b_alt2[6] ? s_b[6] : 1'b1);
  wire t2_nxt   = b_alt2[2] ? s_b[2] : (a_alt3[4] & s_a[4]);
  wire t3_nxt   = b_alt2[3] ? s_b[3] : (a_alt3[5] & s_a[5]);
  wire [3:0] tmr_nxt = {t3_nxt, t2_nxt, b_alt1[5] & s_b[5], b_alt1[4] & s_b[4]};
  // receive from B6, or from the transmit pin in single-wire use
  wire rxd_nxt  = b_alt1[6] ? s_b[6] :
                  ((b_alt1[7] & sci_single_wire_i) ? s_b[7] : 1'b1);
  wire external_clock_input_nxt = b_alt3[6] & oscillator_source_bit_i & s_b[6];
  // slave clock input, master data input
  wire sclk_nxt = b_alt1[0] & ~spi_master_i & s_b[0];
  wire miso_nxt = b_alt1[2] & spi_master_i & s_b[2];
  wire mosi_nxt = b_alt1[3] & ~spi_master_i & s_b[3];

  // a test pin given to port D presents an idle level to the test logic
  assign jt.tck_s = d_peri[2] ? sync2_r[PIN_TCK] : 1'b1;
  assign jt.tms_s = d_peri[3] ? sync2_r[PIN_TMS] : 1'b1;
  assign jt.tdi_s = d_peri[0] ? sync2_r[PIN_TDI] : 1'b1;

  assign gpio_in_o = sync2_r;

  // pads are asynchronous to sys_clk; nothing reads sync1_r but sync2_r
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else if (ce_i) begin
      sync1_r <= pad_in_i;
      sync2_r <= sync1_r;
    end
  end

  // reset leaves every pad undriven with its default pull-up
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pad_out_o <= '0;
      pad_oe_o  <= PAD_OE_RST;
      pad_pu_o  <= PAD_PU_RST;
      ana_en_o  <= ANA_EN_RST;
    end else if (ce_i) begin
      pad_out_o <= out_nxt;
      pad_oe_o  <= oe_nxt;
      pad_pu_o  <= pu_nxt;
      ana_en_o  <= c_peri;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      spi_sclk_rcv_o <= 1'b0;
      spi_ss_n_o     <= 1'b1;
      spi_miso_rcv_o <= 1'b0;
      spi_mosi_rcv_o <= 1'b0;
      i2c_scl_rcv_o  <= 1'b1;
      i2c_sda_rcv_o  <= 1'b1;
      sci_rxd_o      <= 1'b1;
      tmr_rcv_o      <= '0;
      fault_o        <= '0;
      ext_clk_in_o   <= 1'b0;
    end else if (ce_i) begin
      spi_sclk_rcv_o <= sclk_nxt;
      spi_ss_n_o     <= ss_n_nxt;
      spi_miso_rcv_o <= miso_nxt;
      spi_mosi_rcv_o <= mosi_nxt;
      i2c_scl_rcv_o  <= scl_nxt;
      i2c_sda_rcv_o  <= sda_nxt;
      sci_rxd_o      <= rxd_nxt;
      tmr_rcv_o      <= tmr_nxt;
      fault_o        <= fault_nxt;
      ext_clk_in_o   <= external_clock_input_nxt;
    end
  end

  pfm_rst_ctl #(
    .REL_CYC (REL_CYC)
  ) u_rst (
    .sys_clk_i     (sys_clk_i),
    .rst_n_i       (rst_n_i),
    .ce_i          (ce_i),
    .pin_is_gpio_i (rst_pin_gpio_i),
    .rst_pin_lvl_i (sync2_r[PIN_RST]),
    .wdog_rst_i    (wdog_rst_i),
    .sw_rst_i      (sw_rst_i),
    .chip_rst_n_o  (chip_rst_n_o)
  );

  pfm_jtag_pins u_jtag (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .jt          (jt.tap),
    .tap_shift_i (tap_shift_i),
    .tdo_data_i  (tdo_data_i),
    .tck_rise_o  (tck_rise_o),
    .tms_o       (tms_o),
    .tdi_o       (tdi_o)
  );
endmodule
`default_nettype wire

// >>> pin_function_multiplexer_tb.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ns
`default_nettype none
module pin_function_multiplexer_tb;
  import pfm_pkg::*;
  typedef struct packed {
    logic [11:0] pa;
    logic [15:0] pb;
    logic [1:0]  cko;
    logic [2:0]  lv;
    logic        m;
    logic [4:0]  pin;
    logic        eoe;
    logic        eout;
  } pfm_row_s;
  logic            sys_clk_i, rst_n_i, ce_i, rst_pin_gpio_i, oscillator_source_bit_i;
  logic [NPIN-1:0] pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, gpio_dir_i, gpio_dout_i, gpio_in_o;
  logic [NPIN-1:0] ext_en, ext_val;
  logic [7:0]      ana_en_o, pc_gpio_sel_i;
  logic [11:0]     sel_pa_i;
  logic [15:0]     sel_pb_i;
  logic [3:0]      pd_gpio_sel_i, tmr_drv_i, tmr_oe_i, tmr_rcv_o;
  pfm_cko_t        clock_out_source_select_i;
  logic            cko_mstr_i, cko_bus_i, cko_osc_i, ext_clk_in_o, wdog_rst_i, sw_rst_i;
  logic            chip_rst_n_o, spi_master_i, spi_sclk_drv_i, spi_miso_drv_i, spi_mosi_drv_i;
  logic            spi_sclk_rcv_o, spi_ss_n_o, spi_miso_rcv_o, spi_mosi_rcv_o;
  logic            i2c_scl_low_i, i2c_sda_low_i, i2c_scl_rcv_o, i2c_sda_rcv_o;
  logic            sci_txd_i, sci_single_wire_i, sci_txd_oe_i, sci_rxd_o;
  logic [5:0]      modulator_out_i, fault_mask_i;
  logic [2:0]      fault_o;
  logic            tap_shift_i, tdo_data_i, tck_rise_o, tms_o, tdi_o, got_tms, got_tdi;
  int              bad_count, check_count, rises, n;
  localparam pfm_row_s ROWS [13] = '{
    '{12'h000, 16'h0000, 2'h0, 3'h4, 1'h1, 5'h0C, 1'h1, 1'h1},
    '{12'h000, 16'h0000, 2'h0, 3'h4, 1'h0, 5'h0C, 1'h0, 1'h0},
    '{12'h000, 16'h0200, 2'h0, 3'h7, 1'h0, 5'h0C, 1'h1, 1'h0},
    '{12'h000, 16'h0200, 2'h1, 3'h1, 1'h0, 5'h0C, 1'h1, 1'h1},
    '{12'h000, 16'h0200, 2'h2, 3'h2, 1'h0, 5'h0C, 1'h1, 1'h1},
    '{12'h000, 16'h0200, 2'h3, 3'h4, 1'h0, 5'h0C, 1'h1, 1'h1},
    '{12'h000, 16'h0200, 2'h2, 3'h5, 1'h0, 5'h0C, 1'h1, 1'h0},
    '{12'h000, 16'h0001, 2'h0, 3'h1, 1'h1, 5'h08, 1'h1, 1'h1},
    '{12'h000, 16'h0001, 2'h0, 3'h1, 1'h0, 5'h08, 1'h0, 1'h0},
    '{12'h000, 16'h0010, 2'h0, 3'h0, 1'h1, 5'h0A, 1'h0, 1'h0},
    '{12'h001, 16'h0000, 2'h0, 3'h2, 1'h0, 5'h00, 1'h1, 1'h1},
    '{12'h300, 16'h0000, 2'h0, 3'h2, 1'h1, 5'h04, 1'h1, 1'h1},
    '{12'h000, 16'h4000, 2'h0, 3'h1, 1'h1, 5'h0F, 1'h1, 1'h1}
  };

  pfm_top #(.REL_CYC(2)) DUT (.*);
  pfm_board u_board (.sys_clk_i(sys_clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pad_pu_i(pad_pu_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in_i));

  initial begin
    sys_clk_i = 1'h0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (tck_rise_o === 1'h1) begin
      rises++;
      got_tms <= tms_o;
      got_tdi <= tdi_o;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [NPIN-1:0] got, input logic [NPIN-1:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apply(input pfm_row_s r);
    sel_pa_i = r.pa;
    sel_pb_i = r.pb;
    clock_out_source_select_i = r.cko;
    {cko_osc_i, cko_bus_i, cko_mstr_i} = r.lv;
    spi_master_i = r.m;
    gpio_dir_i = {NPIN{r.m}};
    gpio_dout_i = {NPIN{r.lv[2]}};
    spi_sclk_drv_i = r.lv[0];
    sci_txd_i = r.lv[0];
    sci_txd_oe_i = r.m;
    modulator_out_i = {6{r.lv[1]}};
    tmr_drv_i = {4{r.lv[1]}};
    tmr_oe_i = {4{r.m}};
  endtask
  task automatic settle(input int c);
    repeat (c) @(negedge sys_clk_i);
  endtask
  // counts edges until the internal reset lifts
  task automatic wait_run();
    n = 0;
    while (chip_rst_n_o !== 1'h1 && n < 60) begin
      settle(1);
      n++;
    end
  endtask

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    {ce_i, rst_n_i, rst_pin_gpio_i, oscillator_source_bit_i, wdog_rst_i, sw_rst_i} = 6'h20;
    {spi_miso_drv_i, spi_mosi_drv_i, i2c_scl_low_i, i2c_sda_low_i, sci_single_wire_i} = 5'h00;
    {tap_shift_i, tdo_data_i, fault_mask_i, pc_gpio_sel_i, pd_gpio_sel_i} = 20'h00000;
    {ext_en, ext_val, rises} = '0;
    apply(ROWS[1]);
    settle(16);
    check(pad_oe_o, PAD_OE_RST);
    check(pad_pu_o, PAD_PU_RST);
    check({ana_en_o, chip_rst_n_o, spi_ss_n_o}, {ANA_EN_RST, 2'h1});
    rst_n_i = 1'h1;
    wait_run();
    check(n, 3);
    foreach (ROWS[i]) begin
      apply(ROWS[i]);
      settle(2);
      check(pad_oe_o[ROWS[i].pin], ROWS[i].eoe);
      if (ROWS[i].eoe) check(pad_out_o[ROWS[i].pin], ROWS[i].eout);
    end
    sw_rst_i = 1'h1;
    settle(1);
    sw_rst_i = 1'h0;
    wait_run();
    check(n, 3);
    rst_pin_gpio_i = 1'h1;
    {ext_en[PIN_RST], ext_val[PIN_RST]} = 2'h2;
    settle(10);
    check(chip_rst_n_o, 1'h1);
    wdog_rst_i = 1'h1;
    settle(2);
    check(chip_rst_n_o, 1'h0);
    wdog_rst_i = 1'h0;
    rst_pin_gpio_i = 1'h0;
    settle(6);
    check(chip_rst_n_o, 1'h0);
    ext_en = '0;
    wait_run();
    pc_gpio_sel_i = 8'h5A;
    settle(2);
    check({ana_en_o, pad_pu_o[PIN_TCK]}, 9'h14B);
    apply('{12'h201, 16'h0000, 2'h0, 3'h2, 1'h0, 5'h00, 1'h1, 1'h1});
    fault_mask_i = 6'h01;
    {ext_en[4], ext_val[4]} = 2'h3;
    settle(5);
    check({fault_o, pad_out_o[0]}, 4'h2);
    ext_val[4] = 1'h0;
    settle(5);
    check({fault_o, pad_out_o[0]}, 4'h1);
    apply('{12'h000, 16'h8002, 2'h0, 3'h0, 1'h0, 5'h00, 1'h0, 1'h0});
    i2c_scl_low_i = 1'h1;
    settle(2);
    check({pad_oe_o[15], pad_oe_o[8], pad_out_o[15], pad_out_o[8]}, 4'hC);
    i2c_scl_low_i = 1'h0;
    {ext_en[15], ext_val[15], ext_en[8], ext_val[8]} = 4'hE;
    settle(5);
    check(i2c_scl_rcv_o, 1'h0);
    // slave select, slave data out and the clock input alternate on B6
    apply('{12'h000, 16'h3014, 2'h0, 3'h0, 1'h0, 5'h0A, 1'h0, 1'h0});
    {ext_en[9], ext_val[9], ext_en[14], ext_val[14], spi_miso_drv_i, oscillator_source_bit_i} = 6'h2F;
    settle(5);
    check({spi_ss_n_o, pad_oe_o[10], pad_out_o[10], ext_clk_in_o, gpio_in_o[9]}, 5'h0E);
    {tap_shift_i, tdo_data_i} = 2'h3;
    u_board.tap_bit(1'h1, 1'h0);
    settle(3);
    check({rises[1:0], got_tms, got_tdi, pad_oe_o[25], pad_out_o[25]}, 6'h1B);
    tap_shift_i = 1'h0;
    u_board.tap_bit(1'h0, 1'h1);
    settle(3);
    check({rises[1:0], got_tms, got_tdi, pad_oe_o[25]}, 5'h12);
    final_report();
  end
endmodule
`default_nettype wire
